// *** core/dls_pkg.sv ***
// constants shared by the list element sequencer
package dls_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] DLS_OFF_CMD    = 8'h00;
  localparam logic [7:0] DLS_OFF_TAG    = 8'h04;
  localparam logic [7:0] DLS_OFF_LSA    = 8'h08;
  localparam logic [7:0] DLS_OFF_EAH    = 8'h0C;
  localparam logic [7:0] DLS_OFF_LPTR   = 8'h10;
  localparam logic [7:0] DLS_OFF_LLEN   = 8'h14;
  localparam logic [7:0] DLS_OFF_STATUS = 8'h18;
  localparam logic [7:0] DLS_OFF_ACK    = 8'h1C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DLS_CMD_LIST_BIT  = 0;
  localparam int DLS_CMD_S_BIT     = 1;
  localparam int DLS_CMD_PROXY_BIT = 2;
  localparam int DLS_CMD_PUT_BIT   = 3;
  localparam int DLS_TAG_LSB       = 0;
  localparam int DLS_TAG_W         = 5;
  localparam int DLS_BWG_LSB       = 8;
  localparam int DLS_BWG_W         = 8;
  localparam int DLS_ST_BUSY       = 0;
  localparam int DLS_ST_STALLED    = 1;
  localparam int DLS_ST_DONE       = 2;
  localparam int DLS_ST_ERR_CMD    = 3;
  localparam int DLS_ST_ERR_LSZ    = 4;
  localparam int DLS_ST_ERR_LA     = 5;
  localparam int DLS_ST_STALL_TAG  = 8;
  localparam int DLS_ST_DONE_TAG   = 16;
  // element doubleword, bit 0 of the format is bit 63 here
  localparam int DLS_EL_STALL_BIT  = 63;
  localparam int DLS_EL_SIZE_MSB   = 46;
  localparam int DLS_EL_SIZE_LSB   = 32;
  localparam int DLS_EL_SIZE_W     = 15;
  localparam int DLS_EL_EAL_MSB    = 31;

  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] DLS_LIST_MAX_BYTES = 32'h0000_4000;
  localparam logic [31:0] DLS_RST_WORD       = 32'h0000_0000;
  localparam logic [3:0]  DLS_ELEM_BYTES     = 4'h8;
  localparam logic [4:0]  DLS_QW_BYTES       = 5'h10;

  typedef enum logic [2:0] {
    DLS_IDLE,
    DLS_FETCH,
    DLS_WAIT_DATA,
    DLS_ISSUE,
    DLS_WAIT_GUARD,
    DLS_STALL
  } dls_state_t;

endpackage

// *** core/dls_sequencer.sv ***
// list element sequencer for the flow engine with its apb register file
`timescale 1ns/1ps
`default_nettype none

module dls_sequencer #(
  parameter int LS_AW = 18
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      ls_rd_req,
  output logic      [LS_AW-1:0]     ls_rd_addr,
  input  wire logic                 ls_rd_valid,
  input  wire logic [63:0]          ls_rd_data,
  output logic                      xfer_valid,
  input  wire logic                 xfer_ready,
  input  wire logic                 xfer_guarded,
  input  wire logic                 xfer_done,
  output logic      [63:0]          xfer_ea,
  output logic      [LS_AW-1:0]     xfer_lsa,
  output logic      [14:0]          xfer_size,
  output logic                      xfer_put,
  output logic      [4:0]           xfer_tag,
  output logic      [7:0]           xfer_bwg,
  output logic                      stall_event,
  output logic      [4:0]           stall_tag,
  output logic                      list_done,
  output logic      [4:0]           list_done_tag,
  output logic                      busy
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    dls_pkg::dls_state_t state;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic [4:0]          tag;
    logic [7:0]          bwg;
    logic [31:0]         local_store_pointer;
    logic [31:0]         ea_hi;
    logic [31:0]         lptr;
    logic [31:0]         llen;
    logic                put;
    logic [LS_AW-1:0]    cur_lsa;
    logic [LS_AW-1:0]    fetch_addr;
    logic [12:0]         remaining;
    logic                e_stall;
    logic                ls_req;
    logic                x_valid;
    logic [63:0]         x_ea;
    logic [LS_AW-1:0]    x_lsa;
    logic [14:0]         x_size;
    logic                stall_evt;
    logic                done_evt;
    logic [4:0]          done_tag;
    logic [4:0]          stall_tag;
    logic                st_stalled;
    logic                st_done;
    logic                err_cmd;
    logic                err_lsz;
    logic                err_la;
    logic                busy;
  } dls_regs_t;

  dls_regs_t r;
  dls_regs_t n;

  logic             acc;
  logic             idle;
  logic [31:0]      status;
  logic [LS_AW-1:0] size_ext;
  logic [LS_AW-1:0] sum_lsa;
  logic [LS_AW-1:0] next_lsa;
  logic [14:0]      el_size;
  logic [LS_AW-1:0] el_lsa;
  logic             last_elem;
  logic             bad_cmd;

  // ---------------------------------------------------------------
  // element decode and address arithmetic
  // ---------------------------------------------------------------
  assign acc  = psel & penable & ~r.pready;
  assign idle = (r.state == dls_pkg::DLS_IDLE);
  assign last_elem = (r.remaining == 13'h0001);
  assign el_size = ls_rd_data[dls_pkg::DLS_EL_SIZE_MSB:
                              dls_pkg::DLS_EL_SIZE_LSB];
  // small element takes the quadword offset of its ea
  assign el_lsa = ({1'b0, el_size} < 16'(dls_pkg::DLS_QW_BYTES)) ?
                  {r.cur_lsa[LS_AW-1:4], ls_rd_data[3:0]} :
                  r.cur_lsa;
  assign size_ext = LS_AW'(r.x_size);
  assign sum_lsa  = r.x_lsa + size_ext;
  assign next_lsa = (sum_lsa[3:0] != 4'h0) ?
                    {sum_lsa[LS_AW-1:4] + (LS_AW-4)'(1), 4'h0} :
                    sum_lsa;

  always_comb
  begin
    status = dls_pkg::DLS_RST_WORD;
    status[dls_pkg::DLS_ST_BUSY]    = ~idle;
    status[dls_pkg::DLS_ST_STALLED] = r.st_stalled;
    status[dls_pkg::DLS_ST_DONE]    = r.st_done;
    status[dls_pkg::DLS_ST_ERR_CMD] = r.err_cmd;
    status[dls_pkg::DLS_ST_ERR_LSZ] = r.err_lsz;
    status[dls_pkg::DLS_ST_ERR_LA]  = r.err_la;
    status[dls_pkg::DLS_ST_STALL_TAG +: dls_pkg::DLS_TAG_W] = r.stall_tag;
    status[dls_pkg::DLS_ST_DONE_TAG +: dls_pkg::DLS_TAG_W]  = r.done_tag;
  end

  // proxy takes no list, own queue takes no s modifier
  assign bad_cmd = pwdata[dls_pkg::DLS_CMD_PROXY_BIT] ?
                   pwdata[dls_pkg::DLS_CMD_LIST_BIT] :
                   (pwdata[dls_pkg::DLS_CMD_S_BIT] |
                    ~pwdata[dls_pkg::DLS_CMD_LIST_BIT]);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.pready    = 1'b0;
    n.pslverr   = 1'b0;
    n.ls_req    = 1'b0;
    n.stall_evt = 1'b0;
    n.done_evt  = 1'b0;

    // apb slave, answer one cycle into the access phase
    if (acc)
    begin
      n.pready = 1'b1;
      n.prdata = dls_pkg::DLS_RST_WORD;
      if (pwrite)
      begin
        case (paddr)
          dls_pkg::DLS_OFF_CMD:
          begin
            if (!idle)
              n.pslverr = 1'b1;
            else if (bad_cmd)
              n.err_cmd = 1'b1;
            else if ((r.llen[2:0] != 3'h0) ||
                     (r.llen > dls_pkg::DLS_LIST_MAX_BYTES))
              n.err_lsz = 1'b1;
            else if (r.lptr[2:0] != 3'h0)
              n.err_la = 1'b1;
            else if (r.llen == dls_pkg::DLS_RST_WORD)
            begin
              n.done_evt = 1'b1;
              n.done_tag = r.tag;
              n.st_done  = 1'b1;
            end
            else
            begin
              n.put        = pwdata[dls_pkg::DLS_CMD_PUT_BIT];
              n.cur_lsa    = r.local_store_pointer[LS_AW-1:0];
              n.fetch_addr = r.lptr[LS_AW-1:0];
              n.remaining  = r.llen[15:3];
              n.state      = dls_pkg::DLS_FETCH;
            end
          end
          dls_pkg::DLS_OFF_TAG:
          begin
            n.tag = pwdata[dls_pkg::DLS_TAG_LSB +: dls_pkg::DLS_TAG_W];
            n.bwg = pwdata[dls_pkg::DLS_BWG_LSB +: dls_pkg::DLS_BWG_W];
          end
          dls_pkg::DLS_OFF_LSA:  n.local_store_pointer   = pwdata;
          dls_pkg::DLS_OFF_EAH:  n.ea_hi = pwdata;
          dls_pkg::DLS_OFF_LPTR: n.lptr  = pwdata;
          dls_pkg::DLS_OFF_LLEN: n.llen  = pwdata;
          dls_pkg::DLS_OFF_STATUS:
          begin
            // write one to clear, a later hardware set wins
            n.st_done = n.st_done & ~pwdata[dls_pkg::DLS_ST_DONE];
            n.err_cmd = n.err_cmd & ~pwdata[dls_pkg::DLS_ST_ERR_CMD];
            n.err_lsz = n.err_lsz & ~pwdata[dls_pkg::DLS_ST_ERR_LSZ];
            n.err_la  = n.err_la & ~pwdata[dls_pkg::DLS_ST_ERR_LA];
          end
          dls_pkg::DLS_OFF_ACK:
          begin
            if (r.state == dls_pkg::DLS_STALL)
            begin
              n.st_stalled = 1'b0;
              n.state      = dls_pkg::DLS_FETCH;
            end
          end
          default: n.pslverr = 1'b1;
        endcase
      end
      else
      begin
        case (paddr)
          dls_pkg::DLS_OFF_CMD: n.prdata[dls_pkg::DLS_CMD_PUT_BIT] = r.put;
          dls_pkg::DLS_OFF_TAG:
          begin
            n.prdata[dls_pkg::DLS_TAG_LSB +: dls_pkg::DLS_TAG_W] = r.tag;
            n.prdata[dls_pkg::DLS_BWG_LSB +: dls_pkg::DLS_BWG_W] = r.bwg;
          end
          dls_pkg::DLS_OFF_LSA:    n.prdata = r.local_store_pointer;
          dls_pkg::DLS_OFF_EAH:    n.prdata = r.ea_hi;
          dls_pkg::DLS_OFF_LPTR:   n.prdata = r.lptr;
          dls_pkg::DLS_OFF_LLEN:   n.prdata = r.llen;
          dls_pkg::DLS_OFF_STATUS: n.prdata = status;
          dls_pkg::DLS_OFF_ACK:    n.prdata = dls_pkg::DLS_RST_WORD;
          default:                 n.pslverr = 1'b1;
        endcase
      end
    end

    // element sequencer, one element at a time in list order
    case (r.state)
      dls_pkg::DLS_IDLE:
      begin
      end
      dls_pkg::DLS_FETCH:
      begin
        n.ls_req = 1'b1;
        n.state  = dls_pkg::DLS_WAIT_DATA;
      end
      dls_pkg::DLS_WAIT_DATA:
      begin
        if (ls_rd_valid)
        begin
          n.e_stall = ls_rd_data[dls_pkg::DLS_EL_STALL_BIT];
          n.x_size  = el_size;
          n.x_lsa   = el_lsa;
          n.x_ea    = {r.ea_hi,
                       ls_rd_data[dls_pkg::DLS_EL_EAL_MSB:0]};
          n.x_valid = 1'b1;
          n.fetch_addr = r.fetch_addr + LS_AW'(dls_pkg::DLS_ELEM_BYTES);
          n.state   = dls_pkg::DLS_ISSUE;
        end
      end
      dls_pkg::DLS_ISSUE:
      begin
        if (xfer_ready)
        begin
          n.x_valid   = 1'b0;
          n.cur_lsa   = next_lsa;
          n.remaining = r.remaining - 13'h0001;
          if (xfer_guarded)
            n.state = dls_pkg::DLS_WAIT_GUARD;
          else if (last_elem)
          begin
            n.state    = dls_pkg::DLS_IDLE;
            n.done_evt = 1'b1;
            n.done_tag = r.tag;
            n.st_done  = 1'b1;
          end
          else if (r.e_stall)
          begin
            n.state      = dls_pkg::DLS_STALL;
            n.stall_evt  = 1'b1;
            n.stall_tag  = r.tag;
            n.st_stalled = 1'b1;
          end
          else
            n.state = dls_pkg::DLS_FETCH;
        end
      end
      dls_pkg::DLS_WAIT_GUARD:
      begin
        if (xfer_done)
        begin
          // remaining already counted down at issue
          if (r.remaining == 13'h0000)
          begin
            n.state    = dls_pkg::DLS_IDLE;
            n.done_evt = 1'b1;
            n.done_tag = r.tag;
            n.st_done  = 1'b1;
          end
          else if (r.e_stall)
          begin
            n.state      = dls_pkg::DLS_STALL;
            n.stall_evt  = 1'b1;
            n.stall_tag  = r.tag;
            n.st_stalled = 1'b1;
          end
          else
            n.state = dls_pkg::DLS_FETCH;
        end
      end
      dls_pkg::DLS_STALL:
      begin
        // held until the acknowledgment register is written
      end
      default: n.state = dls_pkg::DLS_IDLE;
    endcase
    n.busy = (n.state != dls_pkg::DLS_IDLE);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign ls_rd_req     = r.ls_req;
  assign ls_rd_addr    = r.fetch_addr;
  assign xfer_valid    = r.x_valid;
  assign xfer_ea       = r.x_ea;
  assign xfer_lsa      = r.x_lsa;
  assign xfer_size     = r.x_size;
  assign xfer_put      = r.put;
  assign xfer_tag      = r.tag;
  assign xfer_bwg      = r.bwg;
  assign stall_event   = r.stall_evt;
  assign stall_tag     = r.stall_tag;
  assign list_done     = r.done_evt;
  assign list_done_tag = r.done_tag;
  assign busy          = r.busy;

endmodule

`default_nettype wire

// *** sim/dls_checker.sv ***
// concurrent checks on the list element sequencer ports
`timescale 1ns/1ps
`default_nettype none
module dls_checker #(
  parameter int LS_AW = 18
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic             pready,
  input wire logic             ls_rd_req,
  input wire logic             xfer_valid,
  input wire logic             xfer_ready,
  input wire logic [63:0]      xfer_ea,
  input wire logic [LS_AW-1:0] xfer_lsa,
  input wire logic [14:0]      xfer_size,
  input wire logic             stall_event,
  input wire logic             list_done,
  input wire logic             busy
);
  logic held_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      held_reg <= 1'b0;
    else if (stall_event)
      held_reg <= 1'b1;
    else if (psel && penable && pready && pwrite
             && paddr == dls_pkg::DLS_OFF_ACK)
      held_reg <= 1'b0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_xfer_hold: assert property (
    xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_ea)
      && $stable(xfer_lsa) && $stable(xfer_size))
    else $error("element changed before acceptance");
  a_xfer_drop: assert property (
    xfer_valid && xfer_ready |=> !xfer_valid)
    else $error("element offered twice");
  a_small_lsa: assert property (
    xfer_valid && xfer_size < 15'h10 |-> xfer_lsa[3:0] == xfer_ea[3:0])
    else $error("small element offset mismatch");
  a_big_lsa: assert property (
    xfer_valid && xfer_size >= 15'h10 |-> xfer_lsa[3:0] == 4'h0)
    else $error("local pointer not rounded");
  a_stall_hold: assert property (
    held_reg |-> !ls_rd_req && !xfer_valid)
    else $error("list moved while stalled");
  a_stall_idle: assert property (
    stall_event |-> busy && !xfer_valid && !ls_rd_req)
    else $error("stall without suspend");
  a_done_idle: assert property (
    list_done |-> !busy ##1 !list_done)
    else $error("done while busy");
endmodule
bind dls_sequencer dls_checker #(.LS_AW(LS_AW)) i_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .ls_rd_req,
  .xfer_valid, .xfer_ready, .xfer_ea, .xfer_lsa, .xfer_size, .stall_event,
  .list_done, .busy
);
`default_nettype wire

// *** sim/dls_partner.sv ***
// local store and transfer path model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module dls_partner #(
  parameter int LS_AW = 18
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             slow,
  input  wire logic             guard,
  input  wire logic             ls_rd_req,
  input  wire logic [LS_AW-1:0] ls_rd_addr,
  output logic                  ls_rd_valid,
  output logic      [63:0]      ls_rd_data,
  input  wire logic             xfer_valid,
  output logic                  xfer_ready,
  output logic                  xfer_guarded,
  output logic                  xfer_done,
  input  wire logic [63:0]      xfer_ea,
  input  wire logic [LS_AW-1:0] xfer_lsa,
  input  wire logic [14:0]      xfer_size
);
  logic [63:0]      mem [2048];
  logic [63:0]      log_ea [4096];
  logic [LS_AW-1:0] log_lsa [4096];
  logic [14:0]      log_size [4096];
  int               n_log;
  logic [2:0]       rd_cnt;
  logic [2:0]       dn_cnt;
  logic             ph;
  assign xfer_guarded = guard;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {ls_rd_valid, xfer_ready, xfer_done, ph} <= 4'h0;
      ls_rd_data <= 64'h0;
      rd_cnt <= 3'h0;
      dn_cnt <= 3'h0;
      n_log <= 0;
    end
    else
    begin
      ph <= ~ph;
      ls_rd_valid <= 1'b0;
      // idle data bus never repeats the last word
      ls_rd_data <= ~ls_rd_data;
      if (ls_rd_req)
        rd_cnt <= slow ? 3'h4 : 3'h1;
      else if (rd_cnt != 3'h0)
        rd_cnt <= rd_cnt - 3'h1;
      if (rd_cnt == 3'h1)
      begin
        ls_rd_valid <= 1'b1;
        ls_rd_data <= mem[ls_rd_addr[13:3]];
      end
      xfer_ready <= xfer_valid && !xfer_ready && (ph || !slow);
      xfer_done <= dn_cnt == 3'h1;
      if (dn_cnt != 3'h0)
        dn_cnt <= dn_cnt - 3'h1;
      if (xfer_valid && xfer_ready)
      begin
        log_ea[n_log] <= xfer_ea;
        log_lsa[n_log] <= xfer_lsa;
        log_size[n_log] <= xfer_size;
        n_log <= n_log + 1;
        if (guard)
          dn_cnt <= slow ? 3'h5 : 3'h2;
      end
    end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking testbench for the list element sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int LS_AW = 18;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]       paddr = 8'h0;
  logic [31:0]      pwdata = 32'h0, prdata, rdata;
  logic             pready, pslverr, rerr, busy, slow = 1'b0, guard = 1'b0;
  logic             ls_rd_req, ls_rd_valid, xfer_valid, xfer_ready;
  logic             xfer_guarded, xfer_done, stall_event, list_done, xfer_put;
  logic [7:0]       xfer_bwg;
  logic [LS_AW-1:0] ls_rd_addr, xfer_lsa;
  logic [63:0]      ls_rd_data, xfer_ea;
  logic [14:0]      xfer_size;
  logic [4:0]       stall_tag, list_done_tag, xfer_tag;
  int               failures = 0, n_compared = 0, n_stall = 0, n_done = 0;
  logic [63:0]      el [4] = '{64'h0000_0020_0000_1000,
    64'h8000_0004_0000_2006, 64'h7FFF_8011_FFFF_FFF0,
    64'h8000_0008_0000_3008};
  int               lsa_x [4] = '{'h100, 'h126, 'h130, 'h158};
  int               bc [7] = '{5, 3, 8, 1, 1, 1, 1};
  int               bl [7] = '{0, 0, 0, 0, 0, 4, 0};
  int               bn [7] = '{8, 8, 8, 12, 16392, 8, 0};
  int               bs [7] = '{8, 8, 8, 16, 16, 32, 4};
  dls_sequencer #(.LS_AW(LS_AW)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ls_rd_req, .ls_rd_addr, .ls_rd_valid, .ls_rd_data,
    .xfer_valid, .xfer_ready, .xfer_guarded, .xfer_done, .xfer_ea,
    .xfer_lsa, .xfer_size, .xfer_put, .xfer_tag, .xfer_bwg,
    .stall_event, .stall_tag, .list_done, .list_done_tag, .busy
  );
  dls_partner #(.LS_AW(LS_AW)) i_partner (
    .pclk, .presetn, .slow, .guard, .ls_rd_req, .ls_rd_addr, .ls_rd_valid,
    .ls_rd_data, .xfer_valid, .xfer_ready, .xfer_guarded, .xfer_done,
    .xfer_ea, .xfer_lsa, .xfer_size
  );
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (stall_event === 1'b1) n_stall++;
    if (list_done === 1'b1) n_done++;
  end
  task automatic print_verdict;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer, waits for pready and then releases
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (t >= 20) failures++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wt(ref int c, input int v);
    for (int t = 0; t < 20000 && c < v; t++) @(posedge pclk);
    if (c < v) failures++;
  endtask
  task automatic run(input logic [31:0] cmd, lp, ln);
    apb(1'b1, dls_pkg::DLS_OFF_TAG, 32'h0000_440B);
    apb(1'b1, dls_pkg::DLS_OFF_LSA, 32'h0000_0100);
    apb(1'b1, dls_pkg::DLS_OFF_EAH, 32'h1234_5678);
    apb(1'b1, dls_pkg::DLS_OFF_LPTR, lp);
    apb(1'b1, dls_pkg::DLS_OFF_LLEN, ln);
    apb(1'b1, dls_pkg::DLS_OFF_CMD, cmd);
  endtask
  initial
  begin
    #500_000;
    failures++;
    print_verdict;
  end
  initial
  begin
    int b, s0, d0;
    for (int k = 0; k < 2048; k++) i_partner.mem[k] = 64'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, dls_pkg::DLS_OFF_STATUS, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(rerr, 1'b1);
    b = i_partner.n_log;
    run(32'h1, 32'h0, dls_pkg::DLS_LIST_MAX_BYTES);
    wt(n_done, 1);
    chk(i_partner.n_log - b, 2048);
    for (int k = 0; k < 4; k++) i_partner.mem[8 + k] = el[k];
    for (int k = 0; k < 7; k++)
    begin
      apb(1'b1, dls_pkg::DLS_OFF_STATUS, 32'h0000_003C);
      run(bc[k], bl[k], bn[k]);
      apb(1'b0, dls_pkg::DLS_OFF_STATUS, 32'h0);
      chk(rdata & 32'h3C, bs[k]);
    end
    chk(n_done, 2);
    apb(1'b1, dls_pkg::DLS_OFF_ACK, 32'h0);
    chk({rerr, busy}, 2'b00);
    apb(1'b0, dls_pkg::DLS_OFF_TAG, 32'h0);
    chk(rdata, 32'h0000_440B);
    for (int p = 0; p < 2; p++)
    begin
      slow <= p[0];
      guard <= p[0];
      b = i_partner.n_log;
      s0 = n_stall;
      d0 = n_done;
      run(32'h9, 32'h40, 32'h20);
      wt(n_stall, s0 + 1);
      chk(stall_tag, 5'h0B);
      chk(xfer_tag, 5'h0B);
      chk({xfer_put, xfer_bwg}, 9'h144);
      apb(1'b1, dls_pkg::DLS_OFF_CMD, 32'h9);
      chk(rerr, 1'b1);
      apb(1'b0, dls_pkg::DLS_OFF_STATUS, 32'h0);
      chk(rdata[1], 1'b1);
      repeat (20) @(posedge pclk);
      chk(i_partner.n_log - b, 2);
      apb(1'b1, dls_pkg::DLS_OFF_ACK, 32'h0);
      wt(n_done, d0 + 1);
      chk(n_stall - s0, 1);
      chk(list_done_tag, 5'h0B);
      for (int k = 0; k < 4; k++)
      begin
        chk(i_partner.log_ea[b + k], {32'h1234_5678, el[k][31:0]});
        chk(i_partner.log_lsa[b + k], lsa_x[k]);
        chk(i_partner.log_size[b + k], el[k][46:32]);
      end
    end
    print_verdict;
  end
endmodule
`default_nettype wire
